// *** hdl/pisc_pkg.sv ***
/*
 * pisc_pkg: register offsets, field positions, reset values and mode codes
 * for the input select / holdover control block.
 * assumes a byte-wide register port with 16-bit addresses.
 */
package pisc_pkg;
    localparam logic [15:0] ACTIVE_IN_ADDR    = 16'h0507;
    localparam logic [15:0] NORM_BW_BASE      = 16'h0508;
    localparam logic [15:0] FAST_BW_BASE      = 16'h050e;
    localparam logic [15:0] BW_STROBE_ADDR    = 16'h0514;
    localparam logic [15:0] FB_NUM_BASE       = 16'h0515;
    localparam logic [15:0] FB_DEN_BASE       = 16'h051c;
    localparam logic [15:0] FB_UPD_ADDR       = 16'h0520;
    localparam logic [15:0] IN_SEL_ADDR       = 16'h052a;
    localparam logic [15:0] FAST_LOCK_ADDR    = 16'h052b;
    localparam logic [15:0] HOLD_EXIT_ADDR    = 16'h052c;
    localparam logic [15:0] HOLD_LEN_ADDR     = 16'h052e;
    localparam logic [15:0] HOLD_DLY_ADDR     = 16'h052f;
    localparam logic [15:0] FORCE_HOLD_ADDR   = 16'h0535;
    localparam logic [15:0] SWITCH_CTRL_ADDR  = 16'h0536;
    localparam logic [15:0] ALARM_MASK_ADDR   = 16'h0537;
    localparam logic [15:0] PRIORITY_ADDR     = 16'h0538;
    localparam logic [15:0] REF_SRC_ADDR      = 16'h090e;

    localparam int BW_BYTES  = 6;
    localparam int NUM_BYTES = 7;
    localparam int DEN_BYTES = 4;

    localparam int SEL_BY_REG_BIT = 0;
    localparam int SEL_INPUT_BIT  = 1;
    localparam int FL_AUTO_DIS_BIT = 0;
    localparam int FL_FORCE_BIT   = 1;
    localparam int RAMP_BYP_BIT   = 3;
    localparam int EXIT_BW_BIT    = 4;
    localparam int HSW_BIT        = 2;
    localparam int LOS_MASK_LSB   = 0;
    localparam int OOF_MASK_LSB   = 4;
    localparam int RANK0_LSB      = 0;
    localparam int RANK1_LSB      = 4;
    localparam int ACTIVE_LSB     = 6;

    localparam logic [7:0] HOLD_EXIT_RST = 8'h08;
    localparam logic [2:0] RANK_NONE     = 3'h0;
    localparam logic [2:0] RANK_MAX      = 3'h2;

    typedef enum logic [1:0] {
        SW_MANUAL    = 2'b00,
        SW_AUTO_NREV = 2'b01,
        SW_AUTO_REV  = 2'b10,
        SW_RESERVED  = 2'b11
    } pisc_swmode_t;
endpackage : pisc_pkg

// *** hdl/pisc_ctrl.sv ***
/*
 * pisc_ctrl: configuration registers and control logic for input clock
 * selection, fast lock, holdover and reference choice.
 * assumes a serial-port front end that presents single-cycle byte writes
 * and combinational byte reads on sys_clk; alarm and select pins are async.
 */
`timescale 1ns/1ps
module pisc_ctrl
    import pisc_pkg::*;
(
    input  wire logic         sys_clk,
    input  wire logic         arst_n,
    input  wire logic         regWrEn,
    input  wire logic [15:0]  regAddr,
    input  wire logic [7:0]   regWrData,
    output logic      [7:0]   regRdData,
    input  wire logic         selectPin,
    input  wire logic [1:0]   signalLossAlarm,
    input  wire logic [1:0]   freqOffsetAlarm,
    input  wire logic         pllLocked,
    input  wire logic [31:0]  measFreq,
    input  wire logic         freqSampleStb,
    output logic      [47:0]  loopBwApplied,
    output logic      [55:0]  fbDivNumApplied,
    output logic      [31:0]  fbDivDenApplied,
    output logic              fastLockActive,
    output logic              holdoverActive,
    output logic      [31:0]  holdoverFreq,
    output logic              activeInput,
    output logic              phaseBuildoutEnable,
    output logic              holdoverRampBypass,
    output logic              refPinsExternalClock
);
    localparam int HIST = 32;

    typedef struct packed {
        logic [BW_BYTES-1:0][7:0]  normBw;
        logic [BW_BYTES-1:0][7:0]  fastBw;
        logic [47:0]               normBwApp;
        logic [47:0]               fastBwApp;
        logic                      bwStrobe;
        logic [NUM_BYTES-1:0][7:0] fbNum;
        logic [DEN_BYTES-1:0][7:0] fbDen;
        logic [55:0]               fbNumApp;
        logic [31:0]               fbDenApp;
        logic                      fbUpd;
        logic [1:0]                inSel;
        logic [1:0]                fastLock;
        logic [7:0]                holdExit;
        logic [4:0]                avgLen;
        logic [4:0]                avgDly;
        logic                      forceHold;
        logic [2:0]                swCtrl;
        logic [7:0]                alarmMask;
        logic [7:0]                ranks;
        logic                      refExt;
        logic                      active;
        logic                      holdover;
        logic                      exitFast;
        logic [HIST-1:0][31:0]     hist;
        logic [31:0]               holdFreq;
        logic                      pinSync1;
        logic                      pinSync2;
        logic [1:0]                losSync1;
        logic [1:0]                losSync2;
        logic [1:0]                oofSync1;
        logic [1:0]                oofSync2;
    } pisc_state_t;

    pisc_state_t st_r;
    pisc_state_t st_nxt;

    logic [1:0] usable;
    logic       autoPick;
    logic       anyUsable;
    logic       manualPick;
    logic       inHoldReq;
    logic       fastNow;
    logic [36:0] avgSum;
    logic [5:0] winLen;
    logic [5:0] tapIdx;

    // alarms are used only from the second synchroniser stage
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            usable[i] = (st_r.ranks[(i*4)+:3] != RANK_NONE)
                      && (st_r.ranks[(i*4)+:3] <= RANK_MAX)
                      && !(st_r.losSync2[i] && !st_r.alarmMask[LOS_MASK_LSB+i])
                      && !(st_r.oofSync2[i] && !st_r.alarmMask[OOF_MASK_LSB+i]);
        end
    end

    assign anyUsable = |usable;
    // lower rank wins, ties go to input 0
    assign autoPick = usable[1] && (!usable[0]
                    || (st_r.ranks[RANK1_LSB+:3] < st_r.ranks[RANK0_LSB+:3]));
    assign manualPick = st_r.inSel[SEL_BY_REG_BIT] ? st_r.inSel[SEL_INPUT_BIT]
                                                  : st_r.pinSync2;
    assign inHoldReq = st_r.forceHold
                     || ((st_r.swCtrl[1:0] == SW_AUTO_NREV
                          || st_r.swCtrl[1:0] == SW_AUTO_REV) && !anyUsable);
    assign fastNow = st_r.fastLock[FL_FORCE_BIT]
                   || (!st_r.fastLock[FL_AUTO_DIS_BIT] && !pllLocked)
                   || st_r.exitFast;

    always_comb begin
        avgSum = '0;
        tapIdx = 6'h00;
        winLen = 6'(st_r.avgLen) + 6'h01;
        for (int k = 0; k < HIST; k++) begin
            tapIdx = 6'(k);
            // window starts avgDly samples back, spans avgLen+1 samples
            if (tapIdx >= 6'(st_r.avgDly) && tapIdx < 6'(st_r.avgDly) + winLen) begin
                avgSum = avgSum + 37'(st_r.hist[k]);
            end
        end
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.pinSync1 = selectPin;
        st_nxt.pinSync2 = st_r.pinSync1;
        st_nxt.losSync1 = signalLossAlarm;
        st_nxt.losSync2 = st_r.losSync1;
        st_nxt.oofSync1 = freqOffsetAlarm;
        st_nxt.oofSync2 = st_r.oofSync1;

        if (st_r.bwStrobe) begin
            st_nxt.normBwApp = st_r.normBw;
            st_nxt.fastBwApp = st_r.fastBw;
            st_nxt.bwStrobe  = 1'b0;
        end
        if (st_r.fbUpd) begin
            st_nxt.fbNumApp = st_r.fbNum;
            st_nxt.fbDenApp = st_r.fbDen;
            st_nxt.fbUpd    = 1'b0;
        end

        case (st_r.swCtrl[1:0])
            SW_MANUAL: begin
                st_nxt.active = manualPick;
            end
            SW_AUTO_NREV: begin
                // stays put while current input is still usable
                if (!usable[st_r.active] && anyUsable) begin
                    st_nxt.active = autoPick;
                end
            end
            SW_AUTO_REV: begin
                if (anyUsable) begin
                    st_nxt.active = autoPick;
                end
            end
            default: begin
                st_nxt.active = st_r.active;
            end
        endcase

        st_nxt.holdover = inHoldReq;
        if (st_r.holdover && !inHoldReq) begin
            st_nxt.exitFast = !st_r.holdExit[EXIT_BW_BIT];
        end else if (pllLocked) begin
            st_nxt.exitFast = 1'b0;
        end

        if (freqSampleStb && !st_r.holdover) begin
            st_nxt.hist = {st_r.hist[HIST-2:0], measFreq};
        end
        if (!st_r.holdover) begin
            st_nxt.holdFreq = 32'(avgSum / 37'(winLen));
        end

        if (regWrEn) begin
            for (int b = 0; b < BW_BYTES; b++) begin
                if (regAddr == NORM_BW_BASE + 16'(b)) st_nxt.normBw[b] = regWrData;
                if (regAddr == FAST_BW_BASE + 16'(b)) st_nxt.fastBw[b] = regWrData;
            end
            for (int b = 0; b < NUM_BYTES; b++) begin
                if (regAddr == FB_NUM_BASE + 16'(b)) st_nxt.fbNum[b] = regWrData;
            end
            for (int b = 0; b < DEN_BYTES; b++) begin
                if (regAddr == FB_DEN_BASE + 16'(b)) st_nxt.fbDen[b] = regWrData;
            end
            case (regAddr)
                BW_STROBE_ADDR:   st_nxt.bwStrobe  = st_nxt.bwStrobe | regWrData[0];
                FB_UPD_ADDR:      st_nxt.fbUpd     = regWrData[0];
                IN_SEL_ADDR:      st_nxt.inSel     = regWrData[1:0];
                FAST_LOCK_ADDR:   st_nxt.fastLock  = regWrData[1:0];
                HOLD_EXIT_ADDR:   st_nxt.holdExit  = regWrData;
                HOLD_LEN_ADDR:    st_nxt.avgLen    = regWrData[4:0];
                HOLD_DLY_ADDR:    st_nxt.avgDly    = regWrData[4:0];
                FORCE_HOLD_ADDR:  st_nxt.forceHold = regWrData[0];
                SWITCH_CTRL_ADDR: st_nxt.swCtrl    = regWrData[2:0];
                ALARM_MASK_ADDR:  st_nxt.alarmMask = regWrData & 8'h33;
                PRIORITY_ADDR:    st_nxt.ranks     = regWrData & 8'h77;
                REF_SRC_ADDR:     st_nxt.refExt    = regWrData[0];
                default:          st_nxt.refExt    = st_r.refExt;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r          <= '0;
            st_r.holdExit <= HOLD_EXIT_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_comb begin
        regRdData = 8'h00;
        for (int b = 0; b < BW_BYTES; b++) begin
            if (regAddr == NORM_BW_BASE + 16'(b)) regRdData = st_r.normBw[b];
            if (regAddr == FAST_BW_BASE + 16'(b)) regRdData = st_r.fastBw[b];
        end
        for (int b = 0; b < NUM_BYTES; b++) begin
            if (regAddr == FB_NUM_BASE + 16'(b)) regRdData = st_r.fbNum[b];
        end
        for (int b = 0; b < DEN_BYTES; b++) begin
            if (regAddr == FB_DEN_BASE + 16'(b)) regRdData = st_r.fbDen[b];
        end
        case (regAddr)
            ACTIVE_IN_ADDR:   regRdData = {1'b0, st_r.active, 6'h00};
            BW_STROBE_ADDR:   regRdData = {7'h00, st_r.bwStrobe};
            FB_UPD_ADDR:      regRdData = {7'h00, st_r.fbUpd};
            IN_SEL_ADDR:      regRdData = {6'h00, st_r.inSel};
            FAST_LOCK_ADDR:   regRdData = {6'h00, st_r.fastLock};
            HOLD_EXIT_ADDR:   regRdData = st_r.holdExit;
            HOLD_LEN_ADDR:    regRdData = {3'h0, st_r.avgLen};
            HOLD_DLY_ADDR:    regRdData = {3'h0, st_r.avgDly};
            FORCE_HOLD_ADDR:  regRdData = {7'h00, st_r.forceHold};
            SWITCH_CTRL_ADDR: regRdData = {5'h00, st_r.swCtrl};
            ALARM_MASK_ADDR:  regRdData = st_r.alarmMask;
            PRIORITY_ADDR:    regRdData = st_r.ranks;
            REF_SRC_ADDR:     regRdData = {7'h00, st_r.refExt};
            default:          regRdData = regRdData;
        endcase
    end

    // fast words only while fast lock or fast holdover exit is in force
    assign loopBwApplied        = fastNow ? st_r.fastBwApp : st_r.normBwApp;
    assign fbDivNumApplied      = st_r.fbNumApp;
    assign fbDivDenApplied      = st_r.fbDenApp;
    assign fastLockActive       = fastNow;
    assign holdoverActive       = st_r.holdover;
    assign holdoverFreq         = st_r.holdFreq;
    assign activeInput          = st_r.active;
    assign phaseBuildoutEnable  = st_r.swCtrl[HSW_BIT];
    assign holdoverRampBypass   = st_r.holdExit[RAMP_BYP_BIT];
    assign refPinsExternalClock = st_r.refExt;

    strobe_apply_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        st_r.bwStrobe |=> st_r.normBwApp == $past(st_r.normBw)
                          && st_r.fastBwApp == $past(st_r.fastBw))
        else $error("bandwidth words not applied on strobe");

    strobe_clear_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (st_r.bwStrobe && !(regWrEn && regAddr == BW_STROBE_ADDR && regWrData[0]))
        |=> !st_r.bwStrobe)
        else $error("bandwidth strobe did not clear");

    strobe_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !st_r.bwStrobe |=> $stable(st_r.fastBwApp))
        else $error("fast bandwidth changed without strobe");

    fast_bw_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        st_r.fastLock[FL_FORCE_BIT] |-> loopBwApplied == st_r.fastBwApp)
        else $error("fast bandwidth not used in forced fast lock");

    auto_fast_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (!st_r.fastLock[FL_AUTO_DIS_BIT] && !pllLocked) |-> fastLockActive)
        else $error("auto fast lock missing while unlocked");

    fb_update_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        st_r.fbUpd |=> fbDivNumApplied == $past(st_r.fbNum))
        else $error("numerator not applied on update");

    reg_select_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (st_r.swCtrl[1:0] == SW_MANUAL && st_r.inSel[SEL_BY_REG_BIT])
        ##1 $stable(st_r.inSel) && $stable(st_r.swCtrl)
        |-> activeInput == st_r.inSel[SEL_INPUT_BIT])
        else $error("register selection not followed");

    force_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        st_r.forceHold |=> holdoverActive)
        else $error("force holdover ignored");

    no_input_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (st_r.swCtrl[1:0] == SW_AUTO_REV && !anyUsable) |=> holdoverActive)
        else $error("holdover not entered with no usable input");

    tie_break_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (st_r.swCtrl[1:0] == SW_AUTO_REV && usable == 2'b11
         && st_r.ranks[RANK0_LSB+:3] == st_r.ranks[RANK1_LSB+:3]) |=> !activeInput)
        else $error("tie not broken toward input 0");

    den_update_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        st_r.fbUpd |=> fbDivDenApplied == $past(st_r.fbDen))
        else $error("denominator not applied on update");

    div_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !st_r.fbUpd |=> $stable(fbDivNumApplied) && $stable(fbDivDenApplied))
        else $error("divider words changed without update");

    pin_select_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (st_r.swCtrl[1:0] == SW_MANUAL && !st_r.inSel[SEL_BY_REG_BIT])
        |=> activeInput == $past(st_r.pinSync2))
        else $error("pin selection not followed");

    norm_bw_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !fastLockActive |-> loopBwApplied == st_r.normBwApp)
        else $error("normal bandwidth not used outside fast lock");

    exit_fast_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (holdoverActive && !inHoldReq && !st_r.holdExit[EXIT_BW_BIT]) |=> fastLockActive)
        else $error("fast bandwidth not used on holdover exit");

    exit_norm_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (holdoverActive && !inHoldReq && st_r.holdExit[EXIT_BW_BIT]) |=> !st_r.exitFast)
        else $error("fast bandwidth kept on holdover exit");

    freq_freeze_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        holdoverActive |=> $stable(holdoverFreq) && $stable(st_r.hist))
        else $error("holdover frequency moved during holdover");

    rank_zero_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (st_r.swCtrl[1:0] == SW_AUTO_REV && st_r.ranks[RANK0_LSB+:3] == RANK_NONE
         && anyUsable) |=> activeInput)
        else $error("unselectable input chosen");

    nonrev_stay_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (st_r.swCtrl[1:0] == SW_AUTO_NREV && usable[st_r.active]) |=> $stable(activeInput))
        else $error("non-revertive mode left a usable input");

    mode_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        st_r.swCtrl[1:0] == SW_RESERVED |=> $stable(activeInput))
        else $error("reserved mode changed the input");

    los_mask_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (st_r.swCtrl[1:0] == SW_AUTO_REV && st_r.losSync2[0]
         && !st_r.alarmMask[LOS_MASK_LSB]) |=> activeInput || holdoverActive)
        else $error("unmasked loss alarm ignored");

    nrev_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (st_r.swCtrl[1:0] == SW_AUTO_NREV && !anyUsable) |=> holdoverActive)
        else $error("holdover not entered in non-revertive mode");

    hold_release_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (!st_r.forceHold && st_r.swCtrl[1:0] == SW_MANUAL) |=> !holdoverActive)
        else $error("holdover without force in manual mode");
endmodule : pisc_ctrl

// *** bench/pisc_host_model.sv ***
/*
 * pisc_host_model: host side of the byte register port, turning bench
 * requests into single-cycle writes and held read addresses.
 * assumes requests are raised for exactly one sys_clk edge.
 */
`timescale 1ns/1ps
module pisc_host_model (
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    input  wire logic        reqValid,
    input  wire logic        reqWr,
    input  wire logic [15:0] reqAddr,
    input  wire logic [7:0]  reqData,
    output logic             regWrEn,
    output logic      [15:0] regAddr,
    output logic      [7:0]  regWrData
);
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            regWrEn   <= 1'b0;
            regAddr   <= 16'h0000;
            regWrData <= 8'h00;
        end else begin
            regWrEn   <= reqValid & reqWr;
            regAddr   <= reqValid ? reqAddr : regAddr;
            // idle data is inverted so a stale byte never passes for a write
            regWrData <= (reqValid & reqWr) ? reqData : ~regWrData;
        end
    end
endmodule : pisc_host_model

// *** bench/pisc_ctrl_tb.sv ***
/*
 * pisc_ctrl_tb: self-checking bench for the input select / holdover block.
 * assumes pisc_pkg and pisc_ctrl are compiled first; 40 MHz sys_clk.
 */
`timescale 1ns/1ps
module pisc_ctrl_tb;
    import pisc_pkg::*;
    logic        sys_clk, arst_n, reqValid, reqWr, regWrEn, selectPin;
    logic        pllLocked, freqSampleStb, fastLockActive, holdoverActive;
    logic        activeInput, phaseBuildoutEnable, holdoverRampBypass, refPinsExternalClock;
    logic [15:0] reqAddr, regAddr;
    logic [7:0]  reqData, regWrData, regRdData, rb, raw;
    logic [1:0]  signalLossAlarm, freqOffsetAlarm, signal_loss_alarm, freq_offset_alarm;
    logic [31:0] measFreq, fbDivDenApplied, holdoverFreq, rk, ex;
    logic [47:0] loopBwApplied;
    logic [55:0] fbDivNumApplied;
    logic [63:0] nbw, fbw, num, den;
    logic [31:0] smp [8];
    logic [2:0]  r0, r1;
    logic        u0, u1, e;
    int          seed, mismatches, checked;

    pisc_host_model host (.sys_clk(sys_clk), .arst_n(arst_n), .reqValid(reqValid),
        .reqWr(reqWr), .reqAddr(reqAddr), .reqData(reqData), .regWrEn(regWrEn),
        .regAddr(regAddr), .regWrData(regWrData));
    pisc_ctrl dut (.sys_clk(sys_clk), .arst_n(arst_n), .regWrEn(regWrEn),
        .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
        .selectPin(selectPin), .signalLossAlarm(signalLossAlarm),
        .freqOffsetAlarm(freqOffsetAlarm), .pllLocked(pllLocked), .measFreq(measFreq),
        .freqSampleStb(freqSampleStb), .loopBwApplied(loopBwApplied),
        .fbDivNumApplied(fbDivNumApplied), .fbDivDenApplied(fbDivDenApplied),
        .fastLockActive(fastLockActive), .holdoverActive(holdoverActive),
        .holdoverFreq(holdoverFreq), .activeInput(activeInput),
        .phaseBuildoutEnable(phaseBuildoutEnable), .holdoverRampBypass(holdoverRampBypass),
        .refPinsExternalClock(refPinsExternalClock));

    task automatic test_done();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : test_done

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : cyc

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reqValid <= 1'b1;
        reqWr    <= 1'b1;
        reqAddr  <= a;
        reqData  <= d;
        @(posedge sys_clk);
        reqValid <= 1'b0;
        @(posedge sys_clk);
    endtask : wr

    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reqValid <= 1'b1;
        reqWr    <= 1'b0;
        reqAddr  <= a;
        @(posedge sys_clk);
        reqValid <= 1'b0;
        cyc(1);
        d = regRdData;
    endtask : rd

    // byte count n is the word's width in bytes, least significant first
    task automatic wrw(input logic [15:0] base, input logic [63:0] v, input int n);
        for (int i = 0; i < n; i++)
            wr(base + 16'(i), v[8*i +: 8]);
    endtask : wrw

    function automatic logic usable(logic [2:0] r, logic l, logic o, logic lm, logic om);
        return (r == 3'h1 || r == 3'h2) && !(l && !lm) && !(o && !om);
    endfunction : usable

    task automatic alarms(input logic [1:0] l, input logic [1:0] o);
        @(posedge sys_clk);
        signalLossAlarm <= l;
        freqOffsetAlarm <= o;
        cyc(6);
    endtask : alarms

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    initial begin
        #1000000;
        mismatches++;
        test_done();
    end

    initial begin
        {arst_n, reqValid, reqWr, reqAddr, reqData, selectPin} = '0;
        {signalLossAlarm, freqOffsetAlarm, measFreq, freqSampleStb} = '0;
        pllLocked = 1'b1;
        seed = 32'h65a8;
        repeat (6) @(posedge sys_clk);
        arst_n <= 1'b1;
        rd(HOLD_EXIT_ADDR, rb);
        chk(rb, HOLD_EXIT_RST);
        chk(holdoverRampBypass, 1'b1);
        rd(16'h0600, rb);
        chk(rb, 8'h00);
        wr(HOLD_EXIT_ADDR, 8'h08);
        nbw = {$random(seed), $random(seed)};
        fbw = {$random(seed), $random(seed)};
        wrw(NORM_BW_BASE, nbw, BW_BYTES);
        wrw(FAST_BW_BASE, fbw, BW_BYTES);
        cyc(2);
        chk(loopBwApplied, 48'h0);
        wr(BW_STROBE_ADDR, 8'h01);
        cyc(2);
        chk(loopBwApplied, nbw[47:0]);
        rd(BW_STROBE_ADDR, rb);
        chk(rb, 8'h00);
        @(posedge sys_clk);
        pllLocked <= 1'b0;
        cyc(1);
        chk(fastLockActive, 1'b1);
        chk(loopBwApplied, fbw[47:0]);
        wrw(FAST_BW_BASE, ~fbw, BW_BYTES);
        cyc(2);
        chk(loopBwApplied, fbw[47:0]);
        wr(FAST_LOCK_ADDR, 8'h01);
        cyc(1);
        chk(fastLockActive, 1'b0);
        chk(loopBwApplied, nbw[47:0]);
        @(posedge sys_clk);
        pllLocked <= 1'b1;
        wr(FAST_LOCK_ADDR, 8'h03);
        cyc(1);
        chk(fastLockActive, 1'b1);
        wr(FAST_LOCK_ADDR, 8'h01);
        num = {$random(seed), $random(seed)} & 64'h00ff_ffff_ffff_ffff;
        den = {32'h0, $random(seed)};
        wrw(FB_NUM_BASE, num, NUM_BYTES);
        wrw(FB_DEN_BASE, den, DEN_BYTES);
        rd(FB_NUM_BASE + 16'h0006, rb);
        chk(rb, num[55:48]);
        chk(fbDivNumApplied, 56'h0);
        wr(FB_UPD_ADDR, 8'h01);
        cyc(2);
        chk(fbDivNumApplied, num[55:0]);
        chk(fbDivDenApplied, den[31:0]);
        for (int k = 0; k < 8; k++) begin
            wr(IN_SEL_ADDR, {6'h0, k[1:0]});
            @(posedge sys_clk);
            selectPin <= k[2];
            cyc(6);
            e = k[0] ? k[1] : k[2];
            chk(activeInput, e);
            rd(ACTIVE_IN_ADDR, rb);
            chk(rb[7:6], {1'b0, e});
        end
        wr(SWITCH_CTRL_ADDR, 8'h02);
        for (int i = 0; i < 24; i++) begin
            rk = $random(seed);
            r0 = (rk[1:0] == 2'b11) ? 3'h1 : {1'b0, rk[1:0]};
            r1 = (rk[5:4] == 2'b11) ? 3'h2 : {1'b0, rk[5:4]};
            raw = rk[15:8];
            wr(PRIORITY_ADDR, {1'b0, r1, 1'b0, r0});
            wr(ALARM_MASK_ADDR, raw);
            alarms(rk[17:16], rk[19:18]);
            u0 = usable(r0, rk[16], rk[18], raw[0], raw[4]);
            u1 = usable(r1, rk[17], rk[19], raw[1], raw[5]);
            rd(ALARM_MASK_ADDR, rb);
            chk(rb, raw & 8'h33);
            chk(holdoverActive, !(u0 || u1));
            if (u0 || u1)
                chk(activeInput, !(u0 && (!u1 || r0 <= r1)));
        end
        wr(ALARM_MASK_ADDR, 8'h00);
        wr(PRIORITY_ADDR, 8'h21);
        wr(SWITCH_CTRL_ADDR, 8'h01);
        alarms(2'b01, 2'b00);
        chk(activeInput, 1'b1);
        alarms(2'b00, 2'b00);
        chk(activeInput, 1'b1);
        wr(SWITCH_CTRL_ADDR, 8'h02);
        cyc(4);
        chk(activeInput, 1'b0);
        wr(PRIORITY_ADDR, 8'h12);
        cyc(4);
        chk(activeInput, 1'b1);
        wr(PRIORITY_ADDR, 8'h22);
        cyc(4);
        chk(activeInput, 1'b0);
        wr(SWITCH_CTRL_ADDR, 8'h03);
        wr(PRIORITY_ADDR, 8'h12);
        cyc(4);
        chk(activeInput, 1'b0);
        for (int k = 1; k >= 0; k--) begin
            wr(SWITCH_CTRL_ADDR, {5'h0, k[0], 2'b00});
            wr(REF_SRC_ADDR, {7'h0, k[0]});
            cyc(1);
            chk(phaseBuildoutEnable, k[0]);
            chk(refPinsExternalClock, k[0]);
        end
        wr(HOLD_LEN_ADDR, 8'h01);
        wr(HOLD_DLY_ADDR, 8'h02);
        for (int j = 0; j < 9; j++) begin
            rk = $random(seed);
            if (j < 8)
                smp[j] = {16'h0, rk[15:0]};
            @(posedge sys_clk);
            measFreq <= (j < 8) ? smp[j] : 32'hffff_0000;
            freqSampleStb <= 1'b1;
            @(posedge sys_clk);
            freqSampleStb <= 1'b0;
            cyc(3);
            if (j == 7) begin
                ex = (smp[4] + smp[5]) >> 1;
                chk(holdoverFreq, ex);
                wr(FORCE_HOLD_ADDR, 8'h01);
                cyc(2);
                chk(holdoverActive, 1'b1);
            end
        end
        chk(holdoverFreq, ex);
        @(posedge sys_clk);
        pllLocked <= 1'b0;
        wr(FORCE_HOLD_ADDR, 8'h00);
        cyc(2);
        chk(holdoverActive, 1'b0);
        chk(fastLockActive, 1'b1);
        @(posedge sys_clk);
        pllLocked <= 1'b1;
        cyc(2);
        chk(fastLockActive, 1'b0);
        wr(HOLD_EXIT_ADDR, 8'h18);
        wr(FORCE_HOLD_ADDR, 8'h01);
        @(posedge sys_clk);
        pllLocked <= 1'b0;
        wr(FORCE_HOLD_ADDR, 8'h00);
        cyc(2);
        chk(fastLockActive, 1'b0);
        chk(loopBwApplied, nbw[47:0]);
        test_done();
    end
endmodule : pisc_ctrl_tb
